// ===== src/irq_ctl_pkg.sv
// Purpose: constants shared by the backplane interrupter control logic
// Assumes: 16-bit register port with two byte lanes, short-address offsets
// Notes: offsets are byte addresses as seen on the register port
package irq_ctl_pkg;

   // register offsets
   localparam logic [7:0] INTERRUPT_CONTROL_OFFSET = 8'h2A;
   localparam logic [7:0] INTERRUPT_STATUS_OFFSET = 8'h2A;
   localparam logic [7:0] STATUS_ID_OFFSET = 8'h2C;

   // control register fields
   localparam int LEVEL_MSB = 15;
   localparam int LEVEL_LSB = 13;
   localparam int DEADLOCK_ENABLE_BIT = 11;
   localparam int SYSFAIL_ENABLE_BIT = 9;
   localparam int POWERFAIL_ENABLE_BIT = 8;
   localparam int DIRECT_MSB = 6;
   localparam int DIRECT_LSB = 0;

   // status register fields
   localparam int STAT_POWERFAIL_IRQ_BIT = 12;
   localparam int STAT_DEADLOCK_BIT = 11;
   localparam int STAT_SYSFAIL_LINE_BIT = 9;
   localparam int STAT_POWERFAIL_LINE_BIT = 8;
   localparam int STAT_SYSFAIL_IRQ_BIT = 7;

   // widths and reset values
   localparam int LEVEL_W = 3;
   localparam int LINES = 7;
   localparam logic [2:0] LEVEL_RESET = 3'h0;
   localparam logic [6:0] DIRECT_RESET = 7'h00;
   localparam logic [15:0] STATUS_ID_RESET = 16'h0000;
   localparam logic [15:0] READ_UNMAPPED = 16'h0000;

   typedef logic [LEVEL_W-1:0] level_t;
   typedef logic [LINES-1:0] lines_t;

endpackage : irq_ctl_pkg

// ===== src/local_src_if.sv
// Purpose: carrier between the control register logic and the local sources
// Assumes: single clock domain
// Notes: ctl drives enables and clears, src returns the sticky flags
`timescale 1ns/100ps
interface local_src_if;
   import irq_ctl_pkg::*;
   logic [LEVEL_W-1:0] level;
   logic deadlock_irq_enable;
   logic sysfail_irq_enable;
   logic powerfail_irq_enable;
   logic status_read_clr;
   logic local_ack_clr;
   logic deadlock_status;
   logic sysfail_irq_status;
   logic powerfail_irq_status;
   logic local_pending;

   modport ctl (
      output level, deadlock_irq_enable, sysfail_irq_enable, powerfail_irq_enable,
      output status_read_clr, local_ack_clr,
      input deadlock_status, sysfail_irq_status, powerfail_irq_status, local_pending
   );
   modport src (
      input level, deadlock_irq_enable, sysfail_irq_enable, powerfail_irq_enable,
      input status_read_clr, local_ack_clr,
      output deadlock_status, sysfail_irq_status, powerfail_irq_status, local_pending
   );
endinterface : local_src_if

// ===== src/local_irq_sources.sv
// Purpose: sticky status flags of the three local interrupt conditions
// Assumes: fail lines are active-high levels synchronous to clk
// Notes: a new event in the cycle of its clear always wins
`timescale 1ns/100ps
module local_irq_sources
   import irq_ctl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic hard_reset,
   // conditions
   input wire logic deadlock_event,
   input wire logic sysfail_active,
   input wire logic powerfail_active,
   // carrier
   local_src_if.src bus
);

   logic sysfail_prev;
   logic powerfail_prev;
   logic sysfail_rise;
   logic powerfail_rise;

   assign sysfail_rise = sysfail_active & ~sysfail_prev;
   assign powerfail_rise = powerfail_active & ~powerfail_prev;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sysfail_prev <= 1'b0;
         powerfail_prev <= 1'b0;
      end else if (clk_en) begin
         sysfail_prev <= sysfail_active;
         powerfail_prev <= powerfail_active;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.deadlock_status <= 1'b0;
      end else if (clk_en) begin
         if (deadlock_event) begin
            bus.deadlock_status <= 1'b1;
         end else if (hard_reset || bus.status_read_clr || bus.local_ack_clr) begin
            bus.deadlock_status <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.sysfail_irq_status <= 1'b0;
         bus.powerfail_irq_status <= 1'b0;
      end else if (clk_en) begin
         if (sysfail_rise && bus.sysfail_irq_enable && bus.level != LEVEL_RESET) begin
            bus.sysfail_irq_status <= 1'b1;
         end else if (hard_reset || bus.local_ack_clr) begin
            bus.sysfail_irq_status <= 1'b0;
         end
         if (powerfail_rise && bus.powerfail_irq_enable && bus.level != LEVEL_RESET) begin
            bus.powerfail_irq_status <= 1'b1;
         end else if (hard_reset || bus.local_ack_clr) begin
            bus.powerfail_irq_status <= 1'b0;
         end
      end
   end

   assign bus.local_pending = (bus.level != LEVEL_RESET) &&
      ((bus.deadlock_status && bus.deadlock_irq_enable) ||
       (bus.sysfail_irq_status && bus.sysfail_irq_enable) ||
       (bus.powerfail_irq_status && bus.powerfail_irq_enable));

endmodule : local_irq_sources

// ===== src/vme_interrupter_control.sv
// Purpose: write-only interrupt control, status read-back and acknowledge answer
// Assumes: register and acknowledge strobes are one-cycle pulses synchronous to clk
// Notes: request lines are open-drain; oe low means the line is pulled low
`timescale 1ns/100ps
module vme_interrupter_control
   import irq_ctl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic hard_reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [1:0] reg_be,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // local conditions
   input wire logic deadlock_event,
   input wire logic sysfail_active,
   input wire logic powerfail_active,
   input wire logic [7:0] logical_address,
   // backplane request lines, index 0 is line 1
   input wire logic [6:0] irq_in_n,
   output logic [6:0] irq_out_n,
   output logic [6:0] irq_oe_n,
   // acknowledge cycle
   input wire logic iack_req,
   input wire logic [2:0] iack_level,
   output logic iack_ack,
   output logic iack_pass,
   output logic [15:0] iack_data
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic lines_t level_onehot(input level_t lvl);
      lines_t result;
      result = '0;
      if (lvl != LEVEL_RESET) begin
         result[lvl - 3'h1] = 1'b1;
      end
      return result;
   endfunction : level_onehot

   function automatic lines_t write_mask(input logic [1:0] be);
      return {be[0], be[0], be[0], be[0], be[0], be[0], be[0]};
   endfunction : write_mask

   ////////////////////////////////////////////////////////////////////////////
   // state

   local_src_if src_bus ();

   level_t level;
   logic deadlock_irq_enable;
   logic sysfail_irq_enable;
   logic powerfail_irq_enable;
   lines_t direct_request_drive;
   logic [15:0] status_id_value;

   logic ctl_write;
   logic sid_write;
   logic status_read;
   logic sid_read;
   lines_t local_lines;
   lines_t ack_line;
   logic local_hit;
   logic direct_hit;
   logic [15:0] interrupt_status;
   lines_t next_direct;

   assign src_bus.level = level;
   assign src_bus.deadlock_irq_enable = deadlock_irq_enable;
   assign src_bus.sysfail_irq_enable = sysfail_irq_enable;
   assign src_bus.powerfail_irq_enable = powerfail_irq_enable;

   local_irq_sources sources (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .hard_reset(hard_reset),
      .deadlock_event(deadlock_event),
      .sysfail_active(sysfail_active),
      .powerfail_active(powerfail_active),
      .bus(src_bus.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   assign ctl_write = reg_wr && reg_addr == INTERRUPT_CONTROL_OFFSET;
   assign status_read = reg_rd && reg_addr == INTERRUPT_STATUS_OFFSET;
   assign sid_write = reg_wr && reg_addr == STATUS_ID_OFFSET;
   assign sid_read = reg_rd && reg_addr == STATUS_ID_OFFSET;

   always_comb begin
      interrupt_status = '0;
      interrupt_status[LEVEL_MSB:LEVEL_LSB] = level;
      interrupt_status[STAT_POWERFAIL_IRQ_BIT] = src_bus.powerfail_irq_status;
      interrupt_status[STAT_DEADLOCK_BIT] = src_bus.deadlock_status;
      interrupt_status[STAT_SYSFAIL_LINE_BIT] = sysfail_active;
      interrupt_status[STAT_POWERFAIL_LINE_BIT] = powerfail_active;
      interrupt_status[STAT_SYSFAIL_IRQ_BIT] = src_bus.sysfail_irq_status;
      interrupt_status[DIRECT_MSB:DIRECT_LSB] = ~irq_in_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // acknowledge decision

   assign local_lines = src_bus.local_pending ? level_onehot(level) : '0;
   assign ack_line = level_onehot(iack_level);
   // the local condition answers first when it shares the level with a direct bit
   assign local_hit = iack_req && (local_lines & ack_line) != '0;
   assign direct_hit = iack_req && !local_hit && (direct_request_drive & ack_line) != '0;

   assign src_bus.status_read_clr = clk_en && status_read;
   assign src_bus.local_ack_clr = clk_en && local_hit;

   ////////////////////////////////////////////////////////////////////////////
   // control register fields and status-ID register

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level <= LEVEL_RESET;
      end else if (clk_en) begin
         if (hard_reset) begin
            level <= LEVEL_RESET;
         end else if (ctl_write && reg_be[1]) begin
            level <= reg_wdata[LEVEL_MSB:LEVEL_LSB];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         deadlock_irq_enable <= 1'b0;
         sysfail_irq_enable <= 1'b0;
         powerfail_irq_enable <= 1'b0;
      end else if (clk_en) begin
         if (hard_reset) begin
            deadlock_irq_enable <= 1'b0;
            sysfail_irq_enable <= 1'b0;
            powerfail_irq_enable <= 1'b0;
         end else if (ctl_write && reg_be[1]) begin
            deadlock_irq_enable <= reg_wdata[DEADLOCK_ENABLE_BIT];
            sysfail_irq_enable <= reg_wdata[SYSFAIL_ENABLE_BIT];
            powerfail_irq_enable <= reg_wdata[POWERFAIL_ENABLE_BIT];
         end
      end
   end

   always_comb begin
      next_direct = direct_request_drive;
      if (direct_hit) begin
         next_direct = next_direct & ~ack_line;
      end
      if (ctl_write) begin
         next_direct = (next_direct & ~write_mask(reg_be)) |
            (reg_wdata[DIRECT_MSB:DIRECT_LSB] & write_mask(reg_be));
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         direct_request_drive <= DIRECT_RESET;
      end else if (clk_en) begin
         if (hard_reset) begin
            direct_request_drive <= DIRECT_RESET;
         end else begin
            direct_request_drive <= next_direct;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_id_value <= STATUS_ID_RESET;
      end else if (clk_en) begin
         if (hard_reset) begin
            status_id_value <= STATUS_ID_RESET;
         end else if (sid_write) begin
            if (reg_be[1]) begin
               status_id_value[15:8] <= reg_wdata[15:8];
            end
            if (reg_be[0]) begin
               status_id_value[7:0] <= reg_wdata[7:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request line drivers

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_oe_n <= '1;
         irq_out_n <= '0;
      end else if (clk_en) begin
         irq_oe_n <= ~(direct_request_drive | local_lines);
         irq_out_n <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rvalid <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= reg_rd;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= READ_UNMAPPED;
      end else if (clk_en) begin
         if (status_read) begin
            reg_rdata <= interrupt_status;
         end else if (sid_read) begin
            reg_rdata <= status_id_value;
         end else begin
            reg_rdata <= READ_UNMAPPED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // acknowledge answer

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         iack_ack <= 1'b0;
         iack_pass <= 1'b0;
      end else if (clk_en) begin
         iack_ack <= local_hit || direct_hit;
         iack_pass <= iack_req && !local_hit && !direct_hit;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         iack_data <= '0;
      end else if (clk_en) begin
         if (local_hit) begin
            iack_data <= {interrupt_status[15:8], logical_address};
         end else if (direct_hit) begin
            iack_data <= status_id_value;
         end
      end
   end

endmodule : vme_interrupter_control

// ===== verif/irq_ctl_monitor.sv
// Purpose: port checks of the interrupter control block
// Assumes: clk_en dropped only around a status-ID write, never near control writes
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module irq_ctl_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic hard_reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [1:0] reg_be,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   // lines and acknowledge
   input wire logic [6:0] irq_in_n,
   input wire logic [6:0] irq_out_n,
   input wire logic [6:0] irq_oe_n,
   input wire logic iack_req,
   input wire logic iack_ack,
   input wire logic iack_pass
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   // read and acknowledge answer timing, line and status values
   read_answer_a: assert property (clk_en |=> reg_rvalid == $past(reg_rd))
      else $error("read answer not one cycle after strobe");
   iack_answer_a: assert property (clk_en |=> (iack_ack | iack_pass) == $past(iack_req))
      else $error("acknowledge answer missing or unasked");
   iack_exclusive_a: assert property (!(iack_ack && iack_pass))
      else $error("acknowledge both taken and passed");
   line_value_a: assert property (irq_out_n == 7'h00)
      else $error("request pin value not low");
   status_lines_a: assert property (reg_rd && reg_addr == 8'h2A |=>
      reg_rdata[6:0] == ~$past(irq_in_n))
      else $error("status does not show request lines");
   reserved_zero_a: assert property (reg_rd && reg_addr == 8'h2A |=> !reg_rdata[10])
      else $error("reserved status bit set");
   unmapped_zero_a: assert property (reg_rd && reg_addr != 8'h2A && reg_addr != 8'h2C
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   hard_clear_a: assert property (hard_reset && clk_en |-> ##2 irq_oe_n == 7'h7F)
      else $error("lines not released after hard reset");
   direct_drive_a: assert property (reg_wr && reg_addr == 8'h2A && reg_be[0] && !hard_reset
      ##1 !iack_req && !hard_reset && !reg_wr |=>
      (~irq_oe_n & $past(reg_wdata[6:0], 2)) == $past(reg_wdata[6:0], 2))
      else $error("direct bit did not pull its line");
   direct_ack_c: cover property (iack_req ##1 iack_ack);
   iack_pass_c: cover property (iack_req ##1 iack_pass);
   deadlock_read_c: cover property (reg_rvalid && reg_rdata[11]);
endmodule : irq_ctl_monitor

bind vme_interrupter_control irq_ctl_monitor irq_ctl_monitor_i (.clk, .reset_n, .clk_en,
   .hard_reset, .reg_addr, .reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
   .irq_in_n, .irq_out_n, .irq_oe_n, .iack_req, .iack_ack, .iack_pass);

// ===== verif/iack_handler_model.sv
// Purpose: backplane interrupt handler and pulled-up request lines
// Assumes: one acknowledge at a time
// Notes: gap adds idle cycles to act as a slow handler
`timescale 1ns/100ps
module iack_handler_model (
   // clock
   input wire logic clk,
   // request lines
   input wire logic [6:0] irq_oe_n,
   output logic [6:0] irq_in_n,
   // acknowledge
   output logic iack_req,
   output logic [2:0] iack_level,
   input wire logic iack_ack,
   input wire logic iack_pass,
   input wire logic [15:0] iack_data
);
   // pull-ups: a released line reads high
   assign irq_in_n = irq_oe_n;
   initial begin
      iack_req = 1'b0;
      iack_level = 3'h0;
   end
   task automatic ack_cycle(input logic [2:0] lvl, input int gap, output logic [17:0] ans);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      iack_req <= 1'b1;
      iack_level <= lvl;
      @(posedge clk);
      iack_req <= 1'b0;
      // level bus driven with the inverted level, so it must not be trusted
      iack_level <= ~lvl;
      @(negedge clk);
      ans = {iack_ack, iack_pass, iack_data};
   endtask : ack_cycle
endmodule : iack_handler_model

// ===== verif/vme_interrupter_control_tb.sv
// Purpose: self-checking bench of the interrupter control block
// Assumes: clk_en dropped once to show frozen state, fixed logical address
// Notes: conditions are driven as one vector
`timescale 1ns/100ps
module vme_interrupter_control_tb;
   logic clk, reset_n, clk_en, hard_reset, reg_wr, reg_rd, reg_rvalid;
   logic iack_req, iack_ack, iack_pass;
   logic [7:0] reg_addr;
   logic [1:0] reg_be;
   logic [15:0] reg_wdata, reg_rdata, iack_data;
   logic [2:0] cond, iack_level;
   logic [6:0] irq_in_n, irq_out_n, irq_oe_n;
   logic [17:0] ans;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   vme_interrupter_control vme_interrupter_control_i (.clk, .reset_n, .clk_en,
      .hard_reset, .reg_addr, .reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
      .deadlock_event(cond[2]), .sysfail_active(cond[1]), .powerfail_active(cond[0]),
      .logical_address(8'h5A), .irq_in_n, .irq_out_n, .irq_oe_n, .iack_req, .iack_level,
      .iack_ack, .iack_pass, .iack_data);
   iack_handler_model iack_handler_model_i (.clk, .irq_oe_n, .irq_in_n, .iack_req,
      .iack_level, .iack_ack, .iack_pass, .iack_data);
   ////////////////////////////////////////
   task automatic print_verdict();
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_be <= be;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk({2'b00, reg_rvalid, reg_rdata[14:0]}, {2'b00, 1'b1, exp[14:0]});
      chk({17'h00000, reg_rdata[15]}, {17'h00000, exp[15]});
   endtask : rd
   task automatic lines(input logic [6:0] pulled);
      repeat (3) @(negedge clk);
      chk({11'h000, irq_oe_n}, {11'h000, ~pulled});
   endtask : lines
   task automatic ack(input logic [2:0] lvl, input int gap, input logic [17:0] exp);
      iack_handler_model_i.ack_cycle(lvl, gap, ans);
      chk(ans, exp);
   endtask : ack
   // one local condition: raise, check line, status, pass, answer, release
   task automatic local_case(input logic [15:0] ctl, input logic [2:0] src,
      input logic [2:0] lvl, input logic [15:0] stat);
      wr(8'h2A, 2'b11, ctl);
      @(posedge clk);
      cond <= src;
      @(posedge clk);
      cond[2] <= 1'b0;
      lines(7'h01 << (lvl - 3'h1));
      // a status read would clear the deadlock flag
      if (!src[2]) rd(8'h2A, stat);
      iack_handler_model_i.ack_cycle(lvl ^ 3'h1, 0, ans);
      chk({ans[17:16], 16'h0000}, {2'b01, 16'h0000});
      ack(lvl, 2, {2'b10, stat[15:8], 8'h5A});
      lines(7'h00);
      @(posedge clk);
      cond <= 3'h0;
   endtask : local_case
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      {reset_n, hard_reset, reg_wr, reg_rd} = 4'h0;
      clk_en = 1'b1;
      {reg_addr, reg_be, reg_wdata, cond} = '0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h2A, 16'h0000);
      rd(8'h40, 16'h0000);
      wr(8'h2C, 2'b11, 16'hC3A5);
      rd(8'h2C, 16'hC3A5);
      for (int k = 0; k < 7; k++) begin
         wr(8'h2A, 2'b01, 16'h0001 << k);
         lines(7'h01 << k);
         rd(8'h2A, 16'h0001 << k);
         ack(3'(k + 1), k % 2, {2'b10, 16'hC3A5});
         lines(7'h00);
      end
      local_case(16'h6200, 3'h2, 3'h3, 16'h6284);
      local_case(16'hE100, 3'h1, 3'h7, 16'hF140);
      local_case(16'hA800, 3'h4, 3'h5, 16'hA800);
      // reserved bits written as zero throughout
      wr(8'h2A, 2'b11, 16'h0B00);
      @(posedge clk);
      cond <= 3'h7;
      @(posedge clk);
      cond[2] <= 1'b0;
      lines(7'h00);
      rd(8'h2A, 16'h0B00);
      rd(8'h2A, 16'h0300);
      @(posedge clk);
      cond <= 3'h0;
      wr(8'h2A, 2'b10, 16'h007F);
      lines(7'h00);
      wr(8'h2A, 2'b01, 16'hE07F);
      rd(8'h2A, 16'h007F);
      // a write while the clock enable is low must leave the status-ID untouched
      @(posedge clk);
      clk_en <= 1'b0;
      wr(8'h2C, 2'b11, 16'h1234);
      clk_en <= 1'b1;
      rd(8'h2C, 16'hC3A5);
      @(posedge clk);
      hard_reset <= 1'b1;
      @(posedge clk);
      hard_reset <= 1'b0;
      lines(7'h00);
      rd(8'h2C, 16'h0000);
      rd(8'h2A, 16'h0000);
      print_verdict();
   end
endmodule : vme_interrupter_control_tb
